// ---- core/aacr_pkg.sv ----
// constants and register map of the amplifier control register bank
// Summary of operation
// [R1] any write to offset zero returns every control register to its default
// [R2] reading offset zero returns the fixed 16-bit family identifier
// [R3] bit 7 of both gain registers mutes that output; default muted
// [R4] line output bit 6: zero updates gain at once, one waits for zero cross
// [R5] speaker bit 6: zero updates gain at once, one waits for zero cross
// [R6] bits 5:0 volume code, 0 is -57 dB, 1 dB steps, default 0 dB
// [R7] mid-rail bit 5 enables buffered reference for line output and clamps
// [R8] mid-rail bit 3 controls reference soft start, default zero
// [R9] soft start bit zero selects normal start, one selects soft start
// [R10] reset by offset-zero write ignores data and ends before next access
package aacr_pkg;
  // register offsets
  localparam logic [7:0]  OFS_RESET_IDENT = 8'h00;
  localparam logic [7:0]  OFS_LINE_GAIN   = 8'h02;
  localparam logic [7:0]  OFS_SPK_GAIN    = 8'h03;
  localparam logic [7:0]  OFS_MID_RAIL    = 8'h04;
  // family identifier, value arbitrary
  localparam logic [15:0] FAMILY_IDENT    = 16'h5a3c;
  // field positions
  localparam int          BIT_MUTE        = 7;
  localparam int          BIT_ZERO_CROSS  = 6;
  localparam int          BIT_BUF_ENABLE  = 5;
  localparam int          BIT_SOFT_START  = 3;
  localparam int          VOL_MSB         = 5;
  // reset values and write masks
  localparam logic [7:0]  GAIN_RESET      = 8'hb9;
  localparam logic [5:0]  VOL_0DB         = 6'h39;
  localparam logic [5:0]  MID_RAIL_RESET  = 6'h00;
  localparam logic [15:0] MID_RAIL_MASK   = 16'h0028;
  localparam logic [15:0] GAIN_MASK       = 16'h00ff;
endpackage : aacr_pkg

// ---- core/aacr_regs.sv ----
// register bank for line output, speaker gain and mid-rail reference control
`timescale 1ns/1ns
`default_nettype none
module aacr_regs
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // register access port
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata,
  output logic             rvalid,
  // control outputs
  output logic             line_output_mute,
  output logic             line_output_zero_cross_update,
  output logic      [5:0]  line_output_gain_code,
  output logic             speaker_amp_silence,
  output logic             speaker_amp_zero_cross_update,
  output logic      [5:0]  speaker_amp_gain_code,
  output logic             mid_rail_buffer_enable,
  output logic             mid_rail_soft_start
);

  // ****************************************
  // address match
  // ****************************************
  // one compare shared by every register select
  function automatic logic offset_hit(input logic [7:0] a, input logic [7:0] ofs);
    offset_hit = (a == ofs);
  endfunction : offset_hit

  // ****************************************
  // decode
  // ****************************************
  logic [7:0]  line_reg;
  logic [7:0]  spk_reg;
  logic [15:0] mid_reg;
  logic [15:0] rdata_reg;
  logic        rvalid_reg;
  logic [15:0] rdata_next;

  wire sel_reset = offset_hit(addr, aacr_pkg::OFS_RESET_IDENT);
  wire sel_line  = offset_hit(addr, aacr_pkg::OFS_LINE_GAIN);
  wire sel_spk   = offset_hit(addr, aacr_pkg::OFS_SPK_GAIN);
  wire sel_mid   = offset_hit(addr, aacr_pkg::OFS_MID_RAIL);
  wire soft_rst  = wr_en && sel_reset; // R1 R10

  assign rdata_next = sel_reset ? aacr_pkg::FAMILY_IDENT : // R2
                      sel_line  ? {8'h00, line_reg} :
                      sel_spk   ? {8'h00, spk_reg} :
                      sel_mid   ? mid_reg :
                      16'h0000;

  // ****************************************
  // registers
  // ****************************************
  // line output gain: mute, zero cross update, volume
  always_ff @(posedge clk)
  begin
    if (srst || soft_rst) // R1 R10
    begin
      line_reg <= aacr_pkg::GAIN_RESET; // R3 R4 R6
    end
    else if (wr_en && sel_line)
    begin
      line_reg <= wdata[7:0]; // R3 R4 R6
    end
  end

  // speaker gain: mute, zero cross update, volume
  always_ff @(posedge clk)
  begin
    if (srst || soft_rst) // R1 R10
    begin
      spk_reg <= aacr_pkg::GAIN_RESET; // R3 R5 R6
    end
    else if (wr_en && sel_spk)
    begin
      spk_reg <= wdata[7:0]; // R3 R5 R6
    end
  end

  // mid-rail reference: only buffer enable and soft start are kept
  always_ff @(posedge clk)
  begin
    if (srst || soft_rst) // R1 R10
    begin
      mid_reg <= {10'h000, aacr_pkg::MID_RAIL_RESET}; // R7 R8
    end
    else if (wr_en && sel_mid)
    begin
      mid_reg <= wdata & aacr_pkg::MID_RAIL_MASK; // R7 R8 R9
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rdata_reg  <= rd_en ? rdata_next : 16'h0000;
      rvalid_reg <= rd_en;
    end
  end

  assign rdata                         = rdata_reg;
  assign rvalid                        = rvalid_reg;
  assign line_output_mute              = line_reg[aacr_pkg::BIT_MUTE]; // R3
  assign line_output_zero_cross_update = line_reg[aacr_pkg::BIT_ZERO_CROSS]; // R4
  assign line_output_gain_code         = line_reg[aacr_pkg::VOL_MSB:0]; // R6
  assign speaker_amp_silence           = spk_reg[aacr_pkg::BIT_MUTE]; // R3
  assign speaker_amp_zero_cross_update = spk_reg[aacr_pkg::BIT_ZERO_CROSS]; // R5
  assign speaker_amp_gain_code         = spk_reg[aacr_pkg::VOL_MSB:0]; // R6
  assign mid_rail_buffer_enable        = mid_reg[aacr_pkg::BIT_BUF_ENABLE]; // R7
  assign mid_rail_soft_start           = mid_reg[aacr_pkg::BIT_SOFT_START]; // R8 R9

  // ****************************************
  // checks
  // ****************************************
  chk_soft_reset_defaults: assert property (@(posedge clk) disable iff (srst) // R1
    (wr_en && sel_reset) |=> (line_reg == aacr_pkg::GAIN_RESET && spk_reg == aacr_pkg::GAIN_RESET
                              && mid_reg == 16'h0000))
    else $error("defaults not restored after offset zero write");
  chk_ident_read: assert property (@(posedge clk) disable iff (srst) // R2
    (rd_en && sel_reset) |=> (rdata == aacr_pkg::FAMILY_IDENT && rvalid))
    else $error("identifier read wrong");
  chk_mute_write: assert property (@(posedge clk) disable iff (srst) // R3
    (wr_en && sel_spk) |=> (speaker_amp_silence == $past(wdata[7])))
    else $error("speaker mute not written");
  chk_line_zc: assert property (@(posedge clk) disable iff (srst) // R4
    (wr_en && sel_line) |=> (line_output_zero_cross_update == $past(wdata[6])))
    else $error("line zero cross bit not written");
  chk_spk_zc: assert property (@(posedge clk) disable iff (srst) // R5
    (wr_en && sel_spk) |=> (speaker_amp_zero_cross_update == $past(wdata[6])))
    else $error("speaker zero cross bit not written");
  chk_vol_default: assert property (@(posedge clk) // R6
    srst |=> (line_output_gain_code == aacr_pkg::VOL_0DB && speaker_amp_gain_code == aacr_pkg::VOL_0DB))
    else $error("volume default wrong");
  chk_buf_write: assert property (@(posedge clk) disable iff (srst) // R7
    (wr_en && sel_mid) |=> (mid_rail_buffer_enable == $past(wdata[5])))
    else $error("buffer enable not written");
  chk_soft_start: assert property (@(posedge clk) disable iff (srst) // R9
    (wr_en && sel_mid) |=> (mid_rail_soft_start == $past(wdata[3])))
    else $error("soft start not written");
  chk_reset_any_data: assert property (@(posedge clk) disable iff (srst) // R10
    (wr_en && sel_reset) |=> !mid_rail_buffer_enable && line_output_mute)
    else $error("reset incomplete before next access");
  cov_soft_reset: cover property (@(posedge clk) wr_en && sel_reset);
  cov_ident_read: cover property (@(posedge clk) rd_en && sel_reset);
  cov_unmute: cover property (@(posedge clk) !speaker_amp_silence);
  cov_zero_cross_set: cover property (@(posedge clk) line_output_zero_cross_update);
  cov_soft_start_on: cover property (@(posedge clk) mid_rail_soft_start);

  // reset defaults
  chk_mute_default: assert property (@(posedge clk) // R3
    srst
    |=> (line_output_mute && speaker_amp_silence))
    else $error("mute default wrong");
  chk_mid_default: assert property (@(posedge clk) // R8
    srst
    |=> (!mid_rail_soft_start && !mid_rail_buffer_enable))
    else $error("mid-rail default wrong");
  chk_spk_soft_reset: assert property (@(posedge clk) disable iff (srst) // R3
    (wr_en && sel_reset)
    |=> (speaker_amp_silence && speaker_amp_gain_code == aacr_pkg::VOL_0DB))
    else $error("speaker default not restored");
  chk_zc_soft_reset: assert property (@(posedge clk) disable iff (srst) // R4 R5
    (wr_en && sel_reset)
    |=> (!line_output_zero_cross_update && !speaker_amp_zero_cross_update))
    else $error("zero cross default not restored");
  chk_start_soft_reset: assert property (@(posedge clk) disable iff (srst) // R8
    (wr_en && sel_reset)
    |=> !mid_rail_soft_start)
    else $error("soft start default not restored");

  // write paths
  chk_line_mute_write: assert property (@(posedge clk) disable iff (srst) // R3
    (wr_en && sel_line)
    |=> (line_output_mute == $past(wdata[7])))
    else $error("line mute not written");
  chk_line_vol_write: assert property (@(posedge clk) disable iff (srst) // R6
    (wr_en && sel_line)
    |=> (line_output_gain_code == $past(wdata[5:0])))
    else $error("line volume not written");
  chk_spk_vol_write: assert property (@(posedge clk) disable iff (srst) // R6
    (wr_en && sel_spk)
    |=> (speaker_amp_gain_code == $past(wdata[5:0])))
    else $error("speaker volume not written");
  chk_unmapped_ignored: assert property (@(posedge clk) disable iff (srst) // R6
    (wr_en && !sel_line && !sel_spk && !sel_mid && !sel_reset)
    |=> ($stable(line_output_gain_code) && $stable(speaker_amp_gain_code)))
    else $error("unmapped write changed a volume");

  // read paths
  chk_gain_read_upper: assert property (@(posedge clk) disable iff (srst) // R6
    (rd_en && (sel_line || sel_spk))
    |=> (rdata[15:8] == 8'h00))
    else $error("gain read upper byte not zero");
  chk_mid_read: assert property (@(posedge clk) disable iff (srst) // R7
    (rd_en && sel_mid && !wr_en)
    |=> (rdata[5] == mid_rail_buffer_enable))
    else $error("buffer enable read wrong");
  chk_ident_fixed: assert property (@(posedge clk) disable iff (srst) // R2
    (rd_en && wr_en && sel_reset)
    |=> (rdata == aacr_pkg::FAMILY_IDENT))
    else $error("identifier changed by write");
  chk_rvalid_pulse: assert property (@(posedge clk) disable iff (srst) // R2
    !rd_en
    |=> !rvalid)
    else $error("read valid without read");
endmodule : aacr_regs
`default_nettype wire

// ---- tb/aacr_host.sv ----
// host model issuing register writes and reads
`timescale 1ns/1ns
`default_nettype none
module aacr_host (
  // clock and register access
  input  wire logic        clk,
  output logic             wr_en,
  output logic             rd_en,
  output logic      [7:0]  addr,
  output logic      [15:0] wdata,
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid
);
  initial {wr_en, rd_en, addr, wdata} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [16:0] r);
    @(posedge clk);
    {wr_en, rd_en, addr, wdata} <= {w, !w, a, d};
    @(posedge clk);
    {wr_en, rd_en, addr, wdata} <= {2'b00, ~a, ~d};
    @(posedge clk);
    r = {rvalid, rdata};
  endtask : xfer
endmodule : aacr_host
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the amplifier control register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
  logic        clk = 1'b0, srst = 1'b1, wr_en, rd_en, rvalid, lm, lz, sm, sz, mb, ms;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata;
  logic [5:0]  lv, sv;
  logic [16:0] r;
  wire  [17:0] outs = {lm, lz, lv, sm, sz, sv, mb, ms};
  int          bad_count = 0, checks_done = 0;
  always #25 clk = ~clk;
  aacr_host i_host (.clk, .wr_en, .rd_en, .addr, .wdata, .rdata, .rvalid);
  aacr_regs i_dut (.clk, .srst, .wr_en, .rd_en, .addr, .wdata, .rdata, .rvalid, .line_output_mute(lm),
    .line_output_zero_cross_update(lz), .line_output_gain_code(lv), .speaker_amp_silence(sm),
    .speaker_amp_zero_cross_update(sz), .speaker_amp_gain_code(sv), .mid_rail_buffer_enable(mb),
    .mid_rail_soft_start(ms));
  task automatic rw(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
    i_host.xfer(w, a, d, r);
    `CHK("read", {!w, e}, r)
  endtask : rw
  task automatic t_gain;
    rw(1'b1, 8'h02, 16'h0040, 16'h0000);
    rw(1'b1, 8'h03, 16'hff7f, 16'h0000);
    `CHK("outs", {8'h40, 8'h7f, 2'h0}, outs)
    rw(1'b0, 8'h03, 16'h0000, 16'h007f);
  endtask : t_gain
  task automatic t_mid_reset;
    rw(1'b1, 8'h04, 16'hffff, 16'h0000);
    rw(1'b1, 8'h01, 16'hffff, 16'h0000);
    `CHK("outs", {8'h40, 8'h7f, 2'h3}, outs)
    rw(1'b0, 8'h04, 16'h0000, 16'h0028);
    rw(1'b0, 8'h01, 16'h0000, 16'h0000);
    rw(1'b1, 8'h00, 16'hffff, 16'h0000);
    `CHK("outs", {8'hb9, 8'hb9, 2'h0}, outs)
    rw(1'b0, 8'h00, 16'h0000, aacr_pkg::FAMILY_IDENT);
    rw(1'b0, 8'h02, 16'h0000, 16'h00b9);
  endtask : t_mid_reset
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_gain();
    t_mid_reset();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
